// ===== hdl/kbm_host_if.sv
`default_nettype none
module kbm_host_if
    import kbm_pkg::*;
#(
    parameter int INHIBIT_CYCLES = INHIBIT_CYCLES_DEF,
    parameter int ACK_TIMEOUT_CYCLES = ACK_TIMEOUT_CYCLES_DEF,
    parameter int FRAME_GAP_CYCLES = FRAME_GAP_CYCLES_DEF
) (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    // host i/o port
    input wire kbm_io_req_t io_req_i,
    output logic [7:0] io_rdata_o,
    output logic io_rvalid_o,
    // port base configuration
    input wire logic [7:0] data_port_base_high_config_i,
    input wire logic [7:0] data_port_base_low_config_i,
    input wire logic [7:0] command_port_base_high_config_i,
    input wire logic [7:0] command_port_base_low_config_i,
    // side inputs
    input wire logic kbd_inhibit_b_i,
    input wire logic password_loaded_i,
    // serial links, index 0 keyboard, 1 mouse
    input wire kbm_link_in_t [1:0] link_i,
    output var kbm_link_out_t [1:0] link_o,
    // interrupts
    output logic kbd_irq_o,
    output logic aux_irq_o
);
    localparam int TW = $clog2(ACK_TIMEOUT_CYCLES + 1);
    localparam int GW = $clog2(FRAME_GAP_CYCLES + 1);

    // host side state
    logic ibf;
    logic ib_is_cmd;
    logic [7:0] ib_byte;
    logic await_param;
    logic [7:0] cmd_byte;
    logic obf;
    logic ob_aux;
    logic [7:0] ob_byte;
    logic par_err;
    logic timeout_err;
    logic [1:0] inh_sy;

    // keyboard transmit state
    kbm_tx_state_t tx_state;
    logic [10:0] tx_frame;
    logic [3:0] tx_cnt;
    logic [TW-1:0] tx_tmr;

    // per channel receive results
    logic rx_pend [2];
    logic [7:0] rx_byte [2];
    logic rx_perr [2];
    logic rx_fall [2];
    logic rx_dat [2];
    logic rx_hold [2];
    logic take [2];
    logic clk_drv [2];
    logic dat_drv [2];

    // decode
    logic hit_d;
    logic hit_c;
    logic wr_ok;
    logic rd_d;
    logic [7:0] status;

    assign hit_d = io_req_i.addr == {data_port_base_high_config_i,
                                     data_port_base_low_config_i};
    assign hit_c = io_req_i.addr == {command_port_base_high_config_i,
                                     command_port_base_low_config_i};
    // a write into a full input buffer is dropped, not queued
    assign wr_ok = io_req_i.wr & ~ibf & (hit_d | hit_c);
    assign rd_d = io_req_i.rd & hit_d;

    // command and output buffer steering
    logic cmd_go;
    logic data_go;
    logic resp_cmd;
    logic consume;
    logic tx_start;
    logic ob_load;
    logic [7:0] ob_val;
    logic ob_from_aux;
    logic ob_serial;
    logic ob_perr;
    logic tx_fail;

    always_comb begin
        cmd_go = ibf & ib_is_cmd;
        data_go = ibf & ~ib_is_cmd;
        resp_cmd = (ib_byte == CMD_READ_CB) | (ib_byte == CMD_TEST_PW);
        // answers wait for an empty output buffer so none is overwritten
        tx_start = data_go & ~await_param & (tx_state == TX_IDLE);
        consume = (cmd_go & (~resp_cmd | ~obf)) |
                  (data_go & await_param) | tx_start;
        ob_load = 1'b0;
        ob_val = 8'h00;
        ob_from_aux = 1'b0;
        ob_serial = 1'b0;
        ob_perr = 1'b0;
        take[CH_KBD] = 1'b0;
        take[CH_AUX] = 1'b0;
        if (cmd_go & resp_cmd & ~obf) begin
            ob_load = 1'b1;
            if (ib_byte == CMD_READ_CB) begin
                ob_val = cmd_byte;
            end else begin
                ob_val = password_loaded_i ? PW_LOADED : PW_NONE;
            end
        end else if (~obf & rx_pend[CH_KBD]) begin
            ob_load = 1'b1;
            ob_val = rx_byte[CH_KBD];
            ob_serial = 1'b1;
            ob_perr = rx_perr[CH_KBD];
            take[CH_KBD] = 1'b1;
        end else if (~obf & rx_pend[CH_AUX]) begin
            ob_load = 1'b1;
            ob_val = rx_byte[CH_AUX];
            ob_from_aux = 1'b1;
            ob_serial = 1'b1;
            ob_perr = rx_perr[CH_AUX];
            take[CH_AUX] = 1'b1;
        end
    end

    // input buffer
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ibf <= 1'b0;
            ib_is_cmd <= 1'b0;
            ib_byte <= 8'h00;
        end else if (wr_ok) begin
            ibf <= 1'b1;
            ib_byte <= io_req_i.wdata;
            ib_is_cmd <= hit_c;
        end else if (consume) begin
            ibf <= 1'b0;
        end
    end

    // command byte and parameter wait
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            await_param <= 1'b0;
            cmd_byte <= CB_RESET;
        end else if (consume) begin
            if (cmd_go) begin
                await_param <= ib_byte == CMD_WRITE_CB;
            end else if (await_param) begin
                await_param <= 1'b0;
                cmd_byte <= ib_byte & CB_WRITE_MASK;
            end
        end
    end

    // output buffer
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            obf <= 1'b0;
            ob_aux <= 1'b0;
            ob_byte <= 8'h00;
        end else if (ob_load) begin
            obf <= 1'b1;
            ob_aux <= ob_from_aux;
            ob_byte <= ob_val;
        end else if (rd_d) begin
            obf <= 1'b0;
        end
    end

    // error flags
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            par_err <= 1'b0;
            timeout_err <= 1'b0;
        end else begin
            if (ob_load & ob_serial) begin
                par_err <= ob_perr;
            end
            if (tx_fail) begin
                timeout_err <= 1'b1;
            end else if (tx_start) begin
                timeout_err <= 1'b0;
            end
        end
    end

    // inhibit switch pin
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            inh_sy <= 2'b11;
        end else begin
            inh_sy <= {inh_sy[0], kbd_inhibit_b_i};
        end
    end

    always_comb begin
        status[ST_OBF] = obf;
        status[ST_IBF] = ibf;
        status[ST_SYS] = cmd_byte[CB_SYS_FLAG];
        status[ST_CMD] = ib_is_cmd;
        status[ST_INH] = inh_sy[1];
        status[ST_AUX] = obf & ob_aux;
        status[ST_TMO] = timeout_err;
        status[ST_PERR] = par_err;
    end

    // host read port
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            io_rdata_o <= 8'h00;
            io_rvalid_o <= 1'b0;
        end else begin
            io_rvalid_o <= io_req_i.rd & (hit_d | hit_c);
            if (io_req_i.rd & hit_d) begin
                io_rdata_o <= ob_byte;
            end else if (io_req_i.rd & hit_c) begin
                io_rdata_o <= status;
            end else begin
                io_rdata_o <= 8'h00;
            end
        end
    end

    // interrupts follow the buffer level, gated per source
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            kbd_irq_o <= 1'b0;
            aux_irq_o <= 1'b0;
        end else begin
            kbd_irq_o <= obf & ~ob_aux & cmd_byte[CB_KBD_IRQ_EN];
            aux_irq_o <= obf & ob_aux & cmd_byte[CB_AUX_IRQ_EN];
        end
    end

    // receive channels
    for (genvar ch = 0; ch < 2; ch++) begin : g_rx
        logic [2:0] clk_sy;
        logic [1:0] dat_sy;
        logic [3:0] cnt;
        logic [9:0] shf;
        logic [GW-1:0] gap;
        logic pend;
        logic [7:0] byte_q;
        logic perr;
        logic fall;
        logic dis;
        logic busy_tx;

        assign fall = clk_sy[2] & ~clk_sy[1];
        assign dis = cmd_byte[CB_KBD_DIS + ch];
        assign busy_tx = (ch == CH_KBD) && (tx_state != TX_IDLE);
        assign rx_pend[ch] = pend;
        assign rx_byte[ch] = byte_q;
        assign rx_perr[ch] = perr;
        assign rx_fall[ch] = fall;
        assign rx_dat[ch] = dat_sy[1];
        // clock held low stalls the device while a byte waits
        assign rx_hold[ch] = pend | dis;

        always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
            if (!rst_b_i) begin
                clk_sy <= 3'b111;
                dat_sy <= 2'b11;
            end else begin
                clk_sy <= {clk_sy[1:0], link_i[ch].clk};
                dat_sy <= {dat_sy[0], link_i[ch].dat};
            end
        end

        // a frame left half done by a glitch is dropped after a gap
        always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
            if (!rst_b_i) begin
                gap <= '0;
            end else if (fall | (cnt == 4'd0)) begin
                gap <= '0;
            end else if (gap != GW'(FRAME_GAP_CYCLES - 1)) begin
                gap <= gap + 1'b1;
            end
        end

        always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
            if (!rst_b_i) begin
                cnt <= 4'd0;
                shf <= 10'h000;
                pend <= 1'b0;
                byte_q <= 8'h00;
                perr <= 1'b0;
            end else if (take[ch]) begin
                pend <= 1'b0;
            end else if (rx_hold[ch] | busy_tx) begin
                cnt <= 4'd0;
            end else if (gap == GW'(FRAME_GAP_CYCLES - 1)) begin
                cnt <= 4'd0;
            end else if (fall) begin
                shf <= {dat_sy[1], shf[9:1]};
                if (cnt == RX_LAST_BIT) begin
                    cnt <= 4'd0;
                    // start low and stop high, else the frame is lost
                    if (!shf[0] && dat_sy[1]) begin
                        pend <= 1'b1;
                        byte_q <= shf[8:1];
                        perr <= ~^shf[9:1];
                    end
                end else begin
                    cnt <= cnt + 4'd1;
                end
            end
        end
    end

    // keyboard transmit
    logic tx_to;
    assign tx_to = tx_tmr == TW'(ACK_TIMEOUT_CYCLES - 1);
    assign tx_fail = (((tx_state == TX_SHIFT) | (tx_state == TX_ACK)) & tx_to)
                     | ((tx_state == TX_ACK) & rx_fall[CH_KBD]
                        & rx_dat[CH_KBD]);

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            tx_state <= TX_IDLE;
            tx_frame <= 11'h7ff;
            tx_cnt <= 4'd0;
            tx_tmr <= '0;
        end else begin
            case (tx_state)
                TX_IDLE: begin
                    tx_tmr <= '0;
                    tx_cnt <= 4'd0;
                    if (tx_start) begin
                        tx_state <= TX_INHIBIT;
                        tx_frame <= {1'b1, ~^ib_byte, ib_byte, 1'b0};
                    end
                end
                TX_INHIBIT: begin
                    tx_tmr <= tx_tmr + 1'b1;
                    if (tx_tmr == TW'(INHIBIT_CYCLES - 1)) begin
                        tx_state <= TX_SHIFT;
                    end
                end
                TX_SHIFT: begin
                    tx_tmr <= tx_tmr + 1'b1;
                    if (tx_to) begin
                        tx_state <= TX_IDLE;
                    end else if (rx_fall[CH_KBD]) begin
                        tx_frame <= {1'b1, tx_frame[10:1]};
                        tx_cnt <= tx_cnt + 4'd1;
                        if (tx_cnt == TX_LAST_SHIFT) begin
                            tx_state <= TX_ACK;
                        end
                    end
                end
                TX_ACK: begin
                    tx_tmr <= tx_tmr + 1'b1;
                    // only an ack edge or the time-out frees the sender
                    if (tx_to | rx_fall[CH_KBD]) begin
                        tx_state <= TX_IDLE;
                    end
                end
                default: begin
                    tx_state <= TX_IDLE;
                end
            endcase
        end
    end

    // open-drain pin drive
    always_comb begin
        clk_drv[CH_KBD] = (tx_state == TX_INHIBIT) |
                          ((tx_state == TX_IDLE) & rx_hold[CH_KBD]);
        clk_drv[CH_AUX] = rx_hold[CH_AUX];
        dat_drv[CH_KBD] = ((tx_state == TX_INHIBIT) |
                           (tx_state == TX_SHIFT)) & ~tx_frame[0];
        dat_drv[CH_AUX] = 1'b0;
    end

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            link_o <= '0;
        end else begin
            for (int c = 0; c < 2; c++) begin
                link_o[c].clk_o <= 1'b0;
                link_o[c].clk_oe <= clk_drv[c];
                link_o[c].dat_o <= 1'b0;
                link_o[c].dat_oe <= dat_drv[c];
            end
        end
    end

endmodule
`default_nettype wire

// ===== hdl/kbm_pkg.sv
`default_nettype none
package kbm_pkg;
    // host i/o port defaults
    localparam logic [15:0] DATA_PORT_DEFAULT = 16'h0060;
    localparam logic [15:0] CMD_PORT_DEFAULT = 16'h0064;

    // status bit positions
    localparam int ST_OBF = 0;
    localparam int ST_IBF = 1;
    localparam int ST_SYS = 2;
    localparam int ST_CMD = 3;
    localparam int ST_INH = 4;
    localparam int ST_AUX = 5;
    localparam int ST_TMO = 6;
    localparam int ST_PERR = 7;

    // command byte fields
    localparam int CB_KBD_IRQ_EN = 0;
    localparam int CB_AUX_IRQ_EN = 1;
    localparam int CB_SYS_FLAG = 2;
    localparam int CB_KBD_DIS = 4;
    localparam int CB_AUX_DIS = 5;
    localparam int CB_XLATE = 6;
    localparam logic [7:0] CB_WRITE_MASK = 8'h77;
    localparam logic [7:0] CB_RESET = 8'h00;

    // controller commands and answers
    localparam logic [7:0] CMD_READ_CB = 8'h20;
    localparam logic [7:0] CMD_WRITE_CB = 8'h60;
    localparam logic [7:0] CMD_TEST_PW = 8'ha4;
    localparam logic [7:0] PW_LOADED = 8'hfa;
    localparam logic [7:0] PW_NONE = 8'hf1;

    // timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int INHIBIT_TIME_US = 100;
    localparam int ACK_TIMEOUT_US = 15000;
    localparam int FRAME_GAP_US = 2000;
    localparam int INHIBIT_CYCLES_DEF =
        (INHIBIT_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ACK_TIMEOUT_CYCLES_DEF =
        (ACK_TIMEOUT_US * 1000) / CLK_PERIOD_NS;
    localparam int FRAME_GAP_CYCLES_DEF =
        (FRAME_GAP_US * 1000) / CLK_PERIOD_NS;

    // serial frame
    localparam logic [3:0] RX_LAST_BIT = 4'd10;
    localparam logic [3:0] TX_LAST_SHIFT = 4'd9;
    localparam int CH_KBD = 0;
    localparam int CH_AUX = 1;

    typedef enum logic [1:0] {
        TX_IDLE = 2'b00,
        TX_INHIBIT = 2'b01,
        TX_SHIFT = 2'b11,
        TX_ACK = 2'b10
    } kbm_tx_state_t;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [15:0] addr;
        logic [7:0] wdata;
    } kbm_io_req_t;

    typedef struct packed {
        logic clk;
        logic dat;
    } kbm_link_in_t;

    typedef struct packed {
        logic clk_o;
        logic clk_oe;
        logic dat_o;
        logic dat_oe;
    } kbm_link_out_t;
endpackage
`default_nettype wire

// ===== sim/kbm_dev_model.sv
`default_nettype none
module kbm_dev_model
    import kbm_pkg::*;
(
    // pull-down enables from the host
    input wire logic clk_oe_i,
    input wire logic dat_oe_i,
    // resolved line levels
    output var kbm_link_in_t line_o
);
    timeunit 1ns;
    timeprecision 100ps;
    logic dev_clk = 1'b1;
    logic dev_dat = 1'b1;
    logic ack_en = 1'b1;
    logic [7:0] rx_byte = 8'h00;
    logic [9:0] sh;
    int rx_cnt = 0;
    // open drain with pull-up: any low wins
    assign line_o = {dev_clk & ~clk_oe_i, dev_dat & ~dat_oe_i};
    task automatic bit_out(input logic v);
        dev_dat = v;
        #20 dev_clk = 1'b0;
        #40 dev_clk = 1'b1;
        #20;
    endtask
    // a frame starts only once the host lets the clock go
    task automatic send_byte(input logic [7:0] b, input logic bad);
        wait (line_o.clk === 1'b1);
        bit_out(1'b0);
        for (int i = 0; i < 8; i++) begin
            bit_out(b[i]);
        end
        bit_out(~^b ^ bad);
        bit_out(1'b1);
    endtask
    // level waits: the next frame may open before the ack clock ends
    always begin
        wait (dat_oe_i === 1'b1 && clk_oe_i === 1'b1);
        wait (clk_oe_i === 1'b0);
        #40;
        for (int i = 0; i < 10; i++) begin
            dev_clk = 1'b0;
            #40 dev_clk = 1'b1;
            #30 sh[i] = line_o.dat;
            #10;
        end
        dev_dat = ~ack_en;
        dev_clk = 1'b0;
        #40 dev_clk = 1'b1;
        #40 dev_dat = 1'b1;
        rx_byte = sh[7:0];
        rx_cnt++;
    end
endmodule
`default_nettype wire

// ===== sim/kbm_host_if_asserts.sv
`default_nettype none
module kbm_host_if_chk
    import kbm_pkg::*;
#(
    parameter int INHIBIT_CYCLES = INHIBIT_CYCLES_DEF,
    parameter int ACK_TIMEOUT_CYCLES = ACK_TIMEOUT_CYCLES_DEF,
    parameter int FRAME_GAP_CYCLES = FRAME_GAP_CYCLES_DEF
) (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    // host port
    input wire kbm_io_req_t io_req_i,
    input wire logic [7:0] io_rdata_o,
    input wire logic io_rvalid_o,
    input wire logic [7:0] data_port_base_high_config_i,
    input wire logic [7:0] data_port_base_low_config_i,
    input wire logic [7:0] command_port_base_high_config_i,
    input wire logic [7:0] command_port_base_low_config_i,
    // links and interrupts
    input wire kbm_link_out_t [1:0] link_o,
    input wire logic kbd_irq_o,
    input wire logic aux_irq_o
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rst_b_i);
    wire logic hit_d = io_req_i.addr ==
        {data_port_base_high_config_i, data_port_base_low_config_i};
    wire logic hit_c = io_req_i.addr ==
        {command_port_base_high_config_i, command_port_base_low_config_i};
    logic st_q;
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st_q <= 1'b0;
        end else begin
            st_q <= io_req_i.rd && hit_c;
        end
    end
    sequence s_hit_rd;
        io_req_i.rd && (hit_d || hit_c);
    endsequence
    sequence s_wr_then_st;
        io_req_i.wr && (hit_d || hit_c) ##1 io_req_i.rd && hit_c;
    endsequence
    a_read_answer: assert property (s_hit_rd |=> io_rvalid_o)
        else $error("read of a port got no answer");
    a_idle_quiet: assert property (!(io_req_i.rd && (hit_d || hit_c))
        |=> !io_rvalid_o && io_rdata_o == 8'h00)
        else $error("answer without a decoded read");
    a_ibf_write: assert property (s_wr_then_st |=> io_rdata_o[ST_IBF])
        else $error("input full not shown after write");
    a_irq_excl: assert property (!(kbd_irq_o && aux_irq_o))
        else $error("both interrupts high");
    a_irq_obf: assert property (io_rvalid_o && st_q
        && !io_rdata_o[ST_OBF] |-> !kbd_irq_o && !aux_irq_o)
        else $error("interrupt with empty output buffer");
    a_irq_src: assert property (io_rvalid_o && st_q |->
        (!kbd_irq_o || !io_rdata_o[ST_AUX])
        && (!aux_irq_o || io_rdata_o[ST_AUX]))
        else $error("interrupt source disagrees with status");
    a_open_drain: assert property (!(link_o[0].clk_o || link_o[0].dat_o
        || link_o[1].clk_o || link_o[1].dat_o))
        else $error("link line driven high");
    a_tx_start: assert property ($rose(link_o[0].dat_oe)
        && link_o[0].clk_oe |-> link_o[0].clk_oe [*8])
        else $error("start bit without clock held low");
    a_aux_quiet: assert property (!link_o[1].dat_oe)
        else $error("host data sent to mouse");
endmodule
bind kbm_host_if kbm_host_if_chk #(
    .INHIBIT_CYCLES(INHIBIT_CYCLES),
    .ACK_TIMEOUT_CYCLES(ACK_TIMEOUT_CYCLES),
    .FRAME_GAP_CYCLES(FRAME_GAP_CYCLES)
) u_chk (
    .clk_sys_i(clk_sys_i),
    .rst_b_i(rst_b_i),
    .io_req_i(io_req_i),
    .io_rdata_o(io_rdata_o),
    .io_rvalid_o(io_rvalid_o),
    .data_port_base_high_config_i(data_port_base_high_config_i),
    .data_port_base_low_config_i(data_port_base_low_config_i),
    .command_port_base_high_config_i(command_port_base_high_config_i),
    .command_port_base_low_config_i(command_port_base_low_config_i),
    .link_o(link_o),
    .kbd_irq_o(kbd_irq_o),
    .aux_irq_o(aux_irq_o)
);
`default_nettype wire

// ===== sim/kbm_host_if_tb.sv
`default_nettype none
module kbm_host_if_tb
    import kbm_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_sys_i, rst_b, inh_b, pw, kirq, airq, rvalid;
    logic [7:0] dh, dl, ch, cl, rdata;
    kbm_io_req_t io_req;
    kbm_link_in_t k_ln, a_ln;
    kbm_link_out_t [1:0] lo;
    wire kbm_link_in_t [1:0] lnk = {a_ln, k_ln};
    int fails = 0;
    int checks = 0;
    int cyc = 0;
    kbm_host_if #(
        .INHIBIT_CYCLES(20),
        .ACK_TIMEOUT_CYCLES(4000),
        .FRAME_GAP_CYCLES(400)
    ) dut (
        .clk_sys_i(clk_sys_i),
        .rst_b_i(rst_b),
        .io_req_i(io_req),
        .io_rdata_o(rdata),
        .io_rvalid_o(rvalid),
        .data_port_base_high_config_i(dh),
        .data_port_base_low_config_i(dl),
        .command_port_base_high_config_i(ch),
        .command_port_base_low_config_i(cl),
        .kbd_inhibit_b_i(inh_b),
        .password_loaded_i(pw),
        .link_i(lnk),
        .link_o(lo),
        .kbd_irq_o(kirq),
        .aux_irq_o(airq)
    );
    kbm_dev_model kbd (.clk_oe_i(lo[0].clk_oe), .dat_oe_i(lo[0].dat_oe),
        .line_o(k_ln));
    kbm_dev_model mse (.clk_oe_i(lo[1].clk_oe), .dat_oe_i(lo[1].dat_oe),
        .line_o(a_ln));
    initial begin
        clk_sys_i = 1'b0;
        forever #5 clk_sys_i = ~clk_sys_i;
    end
    task automatic results();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // generous ceiling: the whole run needs well under a third of it
    always @(posedge clk_sys_i) begin
        cyc++;
        if (cyc == 60000) begin
            fails++;
            results();
        end
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic acc(input logic r, input logic [15:0] a,
                       input logic [7:0] d, output logic [7:0] q);
        @(posedge clk_sys_i);
        #1 io_req = {r, ~r, a, d};
        @(posedge clk_sys_i);
        #1 io_req = '0;
        q = rdata;
    endtask
    // write, then read status in the very next cycle
    task automatic wr_st(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk_sys_i);
        #1 io_req = {1'b0, 1'b1, a, d};
        @(posedge clk_sys_i);
        #1 io_req = {1'b1, 1'b0, 16'h0064, 8'h00};
        @(posedge clk_sys_i);
        #1 io_req = '0;
        chk({7'h00, rdata[ST_IBF]}, 8'h01);
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        logic [7:0] q;
        acc(1'b0, a, d, q);
    endtask
    task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp);
        logic [7:0] q;
        acc(1'b1, a, 8'h00, q);
        chk(q, exp);
    endtask
    task automatic wst(input int b, input logic v);
        logic [7:0] s;
        for (int n = 0; n < 3000; n++) begin
            acc(1'b1, 16'h0064, 8'h00, s);
            if (s[b] === v) break;
        end
        chk({7'h00, s[b]}, {7'h00, v});
    endtask
    task automatic wrx(input int n);
        for (int i = 0; i < 3000 && kbd.rx_cnt < n; i++) begin
            @(posedge clk_sys_i);
        end
    endtask
    task automatic set_cb(input logic [7:0] d);
        wr(16'h0064, CMD_WRITE_CB);
        wr(16'h0060, d);
        wst(ST_IBF, 1'b0);
    endtask
    task automatic t_reset();
        rd_chk(16'h0064, 8'h10);
        rd_chk(16'h0061, 8'h00);
    endtask
    task automatic t_cmdbyte();
        set_cb(8'hff);
        wr_st(16'h0064, CMD_READ_CB);
        wst(ST_OBF, 1'b1);
        rd_chk(16'h0064, 8'h1d);
        rd_chk(16'h0060, 8'h77);
        rd_chk(16'h0064, 8'h1c);
        set_cb(8'h03);
        rd_chk(16'h0064, 8'h10);
    endtask
    task automatic t_password();
        for (int i = 0; i < 2; i++) begin
            pw = i[0];
            wr(16'h0064, CMD_TEST_PW);
            wst(ST_OBF, 1'b1);
            rd_chk(16'h0060, i ? PW_LOADED : PW_NONE);
        end
    endtask
    task automatic t_receive();
        kbd.send_byte(8'h5a, 1'b0);
        wst(ST_OBF, 1'b1);
        rd_chk(16'h0064, 8'h19);
        chk({6'h00, airq, kirq}, 8'h01);
        rd_chk(16'h0060, 8'h5a);
        rd_chk(16'h0064, 8'h18);
        chk({6'h00, airq, kirq}, 8'h00);
        mse.send_byte(8'h3c, 1'b1);
        wst(ST_OBF, 1'b1);
        rd_chk(16'h0064, 8'hb9);
        chk({6'h00, airq, kirq}, 8'h02);
        rd_chk(16'h0060, 8'h3c);
        set_cb(8'h00);
        kbd.send_byte(8'h81, 1'b0);
        wst(ST_OBF, 1'b1);
        chk({6'h00, airq, kirq}, 8'h00);
        rd_chk(16'h0060, 8'h81);
        rd_chk(16'h0064, 8'h10);
    endtask
    task automatic t_transmit();
        logic [7:0] s;
        wr(16'h0060, 8'hed);
        wr(16'h0060, 8'hf4);
        acc(1'b1, 16'h0064, 8'h00, s);
        chk({7'h00, s[ST_IBF]}, 8'h01);
        wrx(1);
        chk(kbd.rx_byte, 8'hed);
        wrx(2);
        chk(kbd.rx_byte, 8'hf4);
        rd_chk(16'h0064, 8'h10);
        kbd.ack_en = 1'b0;
        wr(16'h0060, 8'hee);
        wrx(3);
        wst(ST_TMO, 1'b1);
        kbd.ack_en = 1'b1;
    endtask
    task automatic t_inhibit();
        inh_b = 1'b0;
        repeat (3) @(posedge clk_sys_i);
        rd_chk(16'h0064, 8'h40);
        inh_b = 1'b1;
    endtask
    task automatic t_reloc();
        dh = 8'h01;
        pw = 1'b1;
        wr(16'h0064, CMD_TEST_PW);
        wst(ST_OBF, 1'b1);
        rd_chk(16'h0060, 8'h00);
        rd_chk(16'h0160, PW_LOADED);
        dh = 8'h00;
    endtask
    initial begin
        rst_b = 1'b0;
        io_req = '0;
        dh = 8'h00;
        dl = 8'h60;
        ch = 8'h00;
        cl = 8'h64;
        inh_b = 1'b1;
        pw = 1'b0;
        repeat (4) @(posedge clk_sys_i);
        #1 rst_b = 1'b1;
        repeat (2) @(posedge clk_sys_i);
        t_reset();
        t_cmdbyte();
        t_password();
        t_receive();
        t_transmit();
        t_inhibit();
        t_reloc();
        results();
    end
endmodule
`default_nettype wire
